// ### hw/dmms_top.sv
`timescale 1ns/100ps
// Summary of operation
// [R1] user flash: 512 sectors of 128 bytes
// [R2] overlay select low maps boot block low
// [R3] software avoids clearing overlay in low code
// [R4] low internal RAM: direct and indirect
// [R5] upper: indirect to RAM, direct to registers
// [R6] force clear: low moves hit expanded RAM
// [R7] expanded RAM access leaves bus pins idle
// [R8] force clear: high pointer moves use bus
// [R9] force set: every external move uses bus
// [R10] byte address form or full pointer address
// [R11] byte form reaches expanded RAM low page only
// [R12] latch strobe free-runs unless quiet bit set
// [R13] stack stays in internal RAM only
// [R14] two data pointers, select bit picks one
// [R15] select register bit 2 reads zero
// [R16] bit 3 is a plain user flag
// [R17] both registers reset to zero
// [R18] address latch phase precedes data strobe
module dmms_top #(
  parameter int ONCHIP_EXT_RAM_DEPTH = dmms_pkg::ONCHIP_EXT_RAM_DEPTH,
  parameter int ALE_DIV = dmms_pkg::ALE_DIV,
  parameter int STRB_CYC = dmms_pkg::STRB_CYC
) (
  // clock and reset
  input wire logic i_clk,
  input wire logic i_rst,
  // special function register port
  input wire logic [7:0] i_sfr_addr,
  input wire logic i_sfr_wr,
  input wire logic [7:0] i_sfr_wdata,
  output logic [7:0] o_sfr_rdata,
  output logic o_sfr_hit,
  // data pointer operations
  input wire logic i_dp_wr,
  input wire logic [15:0] i_dp_wdata,
  input wire logic i_dp_inc,
  output logic [15:0] o_dp_active,
  // program space
  input wire logic i_boot_overlay_select_n,
  input wire logic [15:0] i_code_addr,
  input wire logic i_code_move,
  output logic o_code_boot,
  output logic [8:0] o_code_sector,
  output logic [6:0] o_code_offset,
  // internal data space
  input wire logic [7:0] i_dat_addr,
  input wire logic i_dat_indirect,
  input wire logic i_dat_stack,
  output logic o_dat_iram,
  output logic o_dat_sfr,
  // external moves
  input wire logic i_xm_req,
  input wire logic i_xm_ri_form,
  input wire logic i_xm_wr,
  input wire logic [7:0] i_xm_ri_addr,
  input wire logic [7:0] i_xm_wdata,
  output logic o_xm_busy,
  output logic o_xm_done,
  output logic [7:0] o_xm_rdata,
  output logic o_xm_on_bus,
  // external bus pins
  input wire logic [7:0] i_lp_in,
  output logic [7:0] o_lp_out,
  output logic o_lp_oe,
  output logic [7:0] o_hp_out,
  output logic o_hp_oe,
  output logic o_ale,
  output logic o_rd_n,
  output logic o_wr_n
);
  import dmms_pkg::*;

  localparam int XIDX_W = $clog2(ONCHIP_EXT_RAM_DEPTH);
  localparam int DIV_W = (ALE_DIV > 1) ? $clog2(ALE_DIV) : 1;
  localparam logic [DIV_W-1:0] DIV_LAST = DIV_W'(ALE_DIV - 1);
  localparam int SECT_W = $clog2(FLASH_SECTORS);
  localparam int OFFS_W = $clog2(SECTOR_BYTES);

  // true when a move stays on chip instead of running a bus cycle
  function automatic logic goes_local(input logic ri_form, input logic force_bus,
                                      input logic [15:0] addr);
    goes_local = !force_bus && (ri_form || (addr <= ONCHIP_EXT_RAM_TOP));
  endfunction

  // auxiliary register fields
  logic ext_force_q;
  logic quiet_q;
  logic psel_q;
  logic flag2_q;
  // data pointers
  logic [15:0] dp0_q;
  logic [15:0] dp1_q;
  // expanded RAM and move results
  logic [7:0] onchip_ext_ram_q [ONCHIP_EXT_RAM_DEPTH];
  logic [7:0] rdata_q;
  logic done_q;
  logic on_bus_q;
  logic local_busy_q;
  logic xb_req_wr_q;
  logic [DIV_W-1:0] div_q;

  wire logic xb_busy;
  wire logic xb_done;
  wire logic [7:0] xb_rdata;
  dmms_pins_t xb_pins;

  // register decode
  wire logic hit_mem = (i_sfr_addr == AUX_MEM_ADDR);
  wire logic hit_psel = (i_sfr_addr == AUX_PSEL_ADDR);
  wire logic wr_mem = i_sfr_wr && hit_mem;
  wire logic wr_psel = i_sfr_wr && hit_psel;

  // read images, reserved bits read zero
  wire logic [7:0] mem_image = {6'h00, ext_force_q, quiet_q};
  wire logic [7:0] psel_image = {4'h0, flag2_q, 1'b0, 1'b0, psel_q}; // [R15]

  assign o_sfr_hit = hit_mem || hit_psel;
  assign o_sfr_rdata = hit_mem ? mem_image : (hit_psel ? psel_image : 8'h00);

  // only defined bits are stored, so an increment of the select
  // register flips the select bit and the carry dies in bit 1
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      ext_force_q <= AUX_RESET[EXT_FORCE_POS]; // [R17]
      quiet_q <= AUX_RESET[QUIET_POS]; // [R17]
      psel_q <= AUX_RESET[PSEL_POS]; // [R17]
      flag2_q <= AUX_RESET[FLAG2_POS]; // [R17]
    end else begin
      if (wr_mem) begin
        ext_force_q <= i_sfr_wdata[EXT_FORCE_POS];
        quiet_q <= i_sfr_wdata[QUIET_POS];
      end
      if (wr_psel) begin
        psel_q <= i_sfr_wdata[PSEL_POS]; // [R15]
        flag2_q <= i_sfr_wdata[FLAG2_POS]; // [R16]
      end
    end
  end

  // dual data pointers
  wire logic [15:0] dp_act = psel_q ? dp1_q : dp0_q; // [R14]
  wire logic [15:0] dp_next = i_dp_wr ? i_dp_wdata : (dp_act + 16'h0001);
  wire logic dp_upd = i_dp_wr || i_dp_inc;

  assign o_dp_active = dp_act;

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      dp0_q <= 16'h0000;
      dp1_q <= 16'h0000;
    end else if (dp_upd) begin
      if (psel_q) begin
        dp1_q <= dp_next; // [R14]
      end else begin
        dp0_q <= dp_next; // [R14]
      end
    end
  end

  // program space: overlay and sector split
  // the core must not drop the overlay select while running low user code
  assign o_code_boot = !i_boot_overlay_select_n && (i_code_addr <= BOOT_TOP); // [R2] [R3]
  assign o_code_sector = i_code_addr[15 -: SECT_W]; // [R1]
  assign o_code_offset = i_code_addr[OFFS_W-1:0]; // [R1]

  // internal data space; stack accesses behave as indirect
  wire logic dat_upper = (i_dat_addr > IRAM_LOW_TOP);
  wire logic dat_ind = i_dat_indirect || i_dat_stack; // [R13]

  assign o_dat_iram = !dat_upper || dat_ind; // [R4] [R5]
  assign o_dat_sfr = dat_upper && !dat_ind; // [R5]

  // external move steering
  wire logic [15:0] xm_addr = i_xm_ri_form ? {8'h00, i_xm_ri_addr} : dp_act; // [R10]
  wire logic xm_idle = !xb_busy && !local_busy_q && !done_q;
  wire logic xm_take = i_xm_req && xm_idle;
  wire logic xm_local = goes_local(i_xm_ri_form, ext_force_q, xm_addr); // [R6] [R11]
  wire logic local_go = xm_take && xm_local;
  wire logic bus_go = xm_take && !xm_local; // [R8] [R9]
  wire logic [XIDX_W-1:0] xidx = xm_addr[XIDX_W-1:0];

  dmms_xreq_t xb_req;
  assign xb_req.ri_form = i_xm_ri_form;
  assign xb_req.wr = i_xm_wr;
  assign xb_req.addr = xm_addr;
  assign xb_req.wdata = i_xm_wdata;

  // storage has no reset; contents are undefined until written
  always_ff @(posedge i_clk) begin
    if (local_go && i_xm_wr) begin
      onchip_ext_ram_q[xidx] <= i_xm_wdata; // [R6]
    end
  end

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      rdata_q <= 8'h00;
      done_q <= 1'b0;
      on_bus_q <= 1'b0;
      local_busy_q <= 1'b0;
    end else begin
      local_busy_q <= local_go;
      done_q <= local_busy_q || xb_done;
      if (local_go) begin
        on_bus_q <= 1'b0;
        if (!i_xm_wr) begin
          rdata_q <= onchip_ext_ram_q[xidx];
        end
      end else if (bus_go) begin
        on_bus_q <= 1'b1;
      end
      if (xb_done && !xb_req_wr_q) begin
        rdata_q <= xb_rdata;
      end
    end
  end

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      xb_req_wr_q <= 1'b0;
    end else if (bus_go) begin
      xb_req_wr_q <= i_xm_wr;
    end
  end

  assign o_xm_busy = !xm_idle;
  assign o_xm_done = done_q;
  assign o_xm_rdata = rdata_q;
  assign o_xm_on_bus = on_bus_q;

  dmms_xbus #(
    .STRB_CYC(STRB_CYC)
  ) u_xbus (
    .i_clk(i_clk),
    .i_rst(i_rst),
    .i_start(bus_go),
    .i_req(xb_req),
    .o_busy(xb_busy),
    .o_done(xb_done),
    .o_rdata(xb_rdata),
    .i_lp_in(i_lp_in),
    .o_pins(xb_pins)
  );

  // free-running latch strobe divider
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      div_q <= '0;
    end else if (div_q == DIV_LAST) begin
      div_q <= '0;
    end else begin
      div_q <= div_q + DIV_W'(1);
    end
  end

  // free pulses are held off during a data bus cycle so the address
  // latch edge belongs only to the sequencer
  wire logic free_pulse = (div_q == '0);
  wire logic free_ok = !xb_busy && (!quiet_q || i_code_move); // [R12]

  assign o_ale = xb_pins.ale || (free_pulse && free_ok); // [R12]
  assign o_lp_out = xb_pins.lp_out;
  assign o_lp_oe = xb_pins.lp_oe; // [R7]
  assign o_hp_out = xb_pins.hp_out;
  assign o_hp_oe = xb_pins.hp_oe; // [R7]
  assign o_rd_n = xb_pins.rd_n; // [R7]
  assign o_wr_n = xb_pins.wr_n; // [R7]

  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_rst);

  boot_overlay_a: assert property ( // [R2]
    o_code_boot == (!i_boot_overlay_select_n && i_code_addr[15:13] == 3'h0))
    else $error("boot overlay mapping wrong");
  sector_split_a: assert property ( // [R1]
    {o_code_sector, o_code_offset} == i_code_addr)
    else $error("sector split does not rebuild address");
  low_ram_a: assert property ( // [R4]
    (i_dat_addr[7] == 1'b0) |-> o_dat_iram && !o_dat_sfr)
    else $error("low internal RAM not selected");
  upper_split_a: assert property ( // [R5]
    i_dat_addr[7] |-> (o_dat_sfr == (!i_dat_indirect && !i_dat_stack)))
    else $error("upper space split wrong");
  stack_iram_a: assert property ( // [R13]
    i_dat_stack |-> o_dat_iram)
    else $error("stack access left internal RAM");
  local_quiet_a: assert property ( // [R7]
    local_go |-> (o_rd_n && o_wr_n && !o_lp_oe && !o_hp_oe) [*3])
    else $error("expanded RAM access disturbed bus pins");
  ri_local_a: assert property ( // [R11]
    (xm_take && i_xm_ri_form && !ext_force_q) |-> local_go ##1 o_rd_n [*4])
    else $error("byte form move left chip with force clear");
  high_bus_a: assert property ( // [R8]
    (xm_take && !i_xm_ri_form && !ext_force_q && dp_act[15:8] >= 8'h03)
      |-> ##[3:4] (!o_rd_n || !o_wr_n))
    else $error("high pointer move ran no bus strobe");
  force_bus_a: assert property ( // [R9]
    (xm_take && ext_force_q) |-> ##[3:4] (!o_rd_n || !o_wr_n))
    else $error("forced move ran no bus strobe");
  ri_high_port_a: assert property ( // [R10]
    (bus_go && i_xm_ri_form) |-> !o_hp_oe [*8])
    else $error("byte form move drove high port");
  quiet_ale_a: assert property ( // [R12]
    (quiet_q && !xb_busy && !i_code_move) |-> !o_ale)
    else $error("latch strobe pulsed while quiet");
  select_read_a: assert property ( // [R15]
    hit_psel |-> (o_sfr_rdata[HARD0_POS] == 1'b0))
    else $error("select register bit 2 read nonzero");
  pointer_pick_a: assert property ( // [R14]
    (dp_upd && !psel_q) |=> (dp1_q == $past(dp1_q)))
    else $error("inactive pointer changed");
endmodule

// ### pkg/dmms_pkg.sv
package dmms_pkg;
  // special function register addresses
  localparam logic [7:0] AUX_MEM_ADDR = 8'h8E;
  localparam logic [7:0] AUX_PSEL_ADDR = 8'hA2;
  localparam logic [7:0] AUX_RESET = 8'h00;
  // field positions
  localparam int EXT_FORCE_POS = 1;
  localparam int QUIET_POS = 0;
  localparam int PSEL_POS = 0;
  localparam int HARD0_POS = 2;
  localparam int FLAG2_POS = 3;
  // map boundaries
  localparam logic [7:0] IRAM_LOW_TOP = 8'h7F;
  localparam logic [15:0] ONCHIP_EXT_RAM_TOP = 16'h02FF;
  localparam int ONCHIP_EXT_RAM_DEPTH = 768;
  localparam logic [15:0] BOOT_TOP = 16'h1FFF;
  localparam int FLASH_SECTORS = 512;
  localparam int SECTOR_BYTES = 128;
  // timing counts in core clock cycles
  localparam int ALE_DIV = 2;
  localparam int STRB_CYC = 6;

  typedef struct packed {
    logic ri_form;
    logic wr;
    logic [15:0] addr;
    logic [7:0] wdata;
  } dmms_xreq_t;

  typedef struct packed {
    logic [7:0] lp_out;
    logic lp_oe;
    logic [7:0] hp_out;
    logic hp_oe;
    logic ale;
    logic rd_n;
    logic wr_n;
  } dmms_pins_t;
endpackage

// ### hw/dmms_xbus.sv
`timescale 1ns/100ps
module dmms_xbus #(
  parameter int STRB_CYC = dmms_pkg::STRB_CYC
) (
  // clock and reset
  input wire logic i_clk,
  input wire logic i_rst,
  // request from steering logic
  input wire logic i_start,
  input wire dmms_pkg::dmms_xreq_t i_req,
  output logic o_busy,
  output logic o_done,
  output logic [7:0] o_rdata,
  // bus pins
  input wire logic [7:0] i_lp_in,
  output dmms_pkg::dmms_pins_t o_pins
);
  import dmms_pkg::*;

  typedef enum logic [2:0] {XB_IDLE, XB_ADDR, XB_HOLD, XB_STRB, XB_DONE} dmms_xst_t;

  localparam logic [3:0] STRB_LAST = 4'(STRB_CYC - 1);

  dmms_xst_t state_q;
  dmms_xreq_t req_q;
  logic [3:0] cnt_q;
  logic [7:0] rdata_q;
  logic [7:0] lp_s1_q;
  logic [7:0] lp_s2_q;
  logic [7:0] lp_s3_q;
  logic [7:0] lp_stable_q;

  wire in_addr = (state_q == XB_ADDR) || (state_q == XB_HOLD);
  wire in_strb = (state_q == XB_STRB);
  wire strb_end = in_strb && (cnt_q == STRB_LAST);

  // pin input: a value counts once two later stages agree
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      lp_s1_q <= 8'h00;
      lp_s2_q <= 8'h00;
      lp_s3_q <= 8'h00;
      lp_stable_q <= 8'h00;
    end else begin
      lp_s1_q <= i_lp_in;
      lp_s2_q <= lp_s1_q;
      lp_s3_q <= lp_s2_q;
      if (lp_s2_q == lp_s3_q) begin
        lp_stable_q <= lp_s3_q;
      end
    end
  end

  // address with latch strobe, hold, then data strobe
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      state_q <= XB_IDLE;
      req_q <= '0;
      cnt_q <= 4'h0;
      rdata_q <= 8'h00;
    end else begin
      case (state_q)
        XB_IDLE: begin
          if (i_start) begin
            req_q <= i_req;
            state_q <= XB_ADDR; // [R18]
          end
        end
        XB_ADDR: state_q <= XB_HOLD;
        XB_HOLD: begin
          cnt_q <= 4'h0;
          state_q <= XB_STRB; // [R18]
        end
        XB_STRB: begin
          cnt_q <= cnt_q + 4'h1;
          if (strb_end) begin
            // sampled late in the strobe so the pin sync has settled
            if (!req_q.wr) begin
              rdata_q <= lp_stable_q;
            end
            state_q <= XB_DONE;
          end
        end
        XB_DONE: state_q <= XB_IDLE;
        default: state_q <= XB_IDLE;
      endcase
    end
  end

  assign o_busy = (state_q != XB_IDLE);
  assign o_done = (state_q == XB_DONE);
  assign o_rdata = rdata_q;
  assign o_pins.ale = (state_q == XB_ADDR); // [R18]
  assign o_pins.lp_out = in_addr ? req_q.addr[7:0] : req_q.wdata; // [R10]
  assign o_pins.lp_oe = in_addr || (in_strb && req_q.wr);
  // register-indirect form leaves the high port to the user
  assign o_pins.hp_out = req_q.addr[15:8]; // [R10]
  assign o_pins.hp_oe = (in_addr || in_strb) && !req_q.ri_form; // [R10]
  assign o_pins.rd_n = !(in_strb && !req_q.wr);
  assign o_pins.wr_n = !(in_strb && req_q.wr);

  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_rst);

  strobe_after_ale_a: assert property ( // [R18]
    $rose(in_strb) |-> $past(state_q == XB_HOLD) && $past(o_pins.ale, 2))
    else $error("data strobe not preceded by address latch phase");
  strobe_len_a: assert property ( // [R18]
    $rose(in_strb) |-> in_strb [*6] ##1 !in_strb)
    else $error("data strobe length wrong");
endmodule

// ### bench/dmms_xmem_model.sv
`timescale 1ns/100ps
module dmms_xmem_model (
  // clock
  input wire logic i_clk,
  // device bus pins
  input wire logic [7:0] i_lp_out,
  input wire logic i_lp_oe,
  input wire logic [7:0] i_hp_out,
  input wire logic i_hp_oe,
  input wire logic i_ale,
  input wire logic i_rd_n,
  input wire logic i_wr_n,
  // resolved low port level, latched address
  output logic [7:0] o_lp_level,
  output logic [15:0] o_addr
);
  logic [7:0] mem_q [0:65535];
  logic [7:0] wdat_q;
  logic [7:0] prev_q = 8'h00;
  logic wr_n_q = 1'b1;
  initial o_addr = 16'h0000;
  // released port shows a changing pattern, never the last value
  assign o_lp_level = i_lp_oe ? i_lp_out : (!i_rd_n ? mem_q[o_addr] : ~prev_q);
  always @(posedge i_clk) begin
    prev_q <= o_lp_level;
    wr_n_q <= i_wr_n;
    if (i_ale && i_lp_oe) begin
      o_addr <= {(i_hp_oe ? i_hp_out : 8'h00), i_lp_out};
    end
    if (!i_wr_n) wdat_q <= i_lp_out;
    if (i_wr_n && !wr_n_q) mem_q[o_addr] <= wdat_q;
  end
endmodule

// ### bench/tb.sv
`timescale 1ns/100ps
module tb;
  import dmms_pkg::*;
  logic i_clk = 1'b0;
  logic i_rst = 1'b1;
  logic [7:0] sa = 8'h00, swd = 8'h00, srd, xra = 8'h00, xwd = 8'h00, xrd, lpi, lpo, hpo;
  logic sw = 1'b0, hit, dpw = 1'b0, dpi = 1'b0, bootn = 1'b1, cmv = 1'b0;
  logic [15:0] dpd = 16'h0000, dpa, ca = 16'h0000, maddr;
  logic cboot, ind = 1'b0, stk = 1'b0, iram, sfr, xq = 1'b0, xri = 1'b0, xw = 1'b0;
  logic busy, done, onbus, lpoe, hpoe, ale, rdn, wrn, s_strb, s_port, s_hp;
  logic [8:0] csec;
  logic [6:0] coff;
  logic [7:0] da = 8'h00;
  int err_total = 0;
  int comparisons = 0;
  int c;

  always #10 i_clk = ~i_clk;

  dmms_top i_dut (.i_clk(i_clk), .i_rst(i_rst), .i_sfr_addr(sa), .i_sfr_wr(sw),
    .i_sfr_wdata(swd), .o_sfr_rdata(srd), .o_sfr_hit(hit), .i_dp_wr(dpw),
    .i_dp_wdata(dpd), .i_dp_inc(dpi), .o_dp_active(dpa), .i_boot_overlay_select_n(bootn),
    .i_code_addr(ca), .i_code_move(cmv), .o_code_boot(cboot), .o_code_sector(csec),
    .o_code_offset(coff), .i_dat_addr(da), .i_dat_indirect(ind), .i_dat_stack(stk),
    .o_dat_iram(iram), .o_dat_sfr(sfr), .i_xm_req(xq), .i_xm_ri_form(xri), .i_xm_wr(xw),
    .i_xm_ri_addr(xra), .i_xm_wdata(xwd), .o_xm_busy(busy), .o_xm_done(done),
    .o_xm_rdata(xrd), .o_xm_on_bus(onbus), .i_lp_in(lpi), .o_lp_out(lpo), .o_lp_oe(lpoe),
    .o_hp_out(hpo), .o_hp_oe(hpoe), .o_ale(ale), .o_rd_n(rdn), .o_wr_n(wrn));

  dmms_xmem_model i_mem (.i_clk(i_clk), .i_lp_out(lpo), .i_lp_oe(lpoe), .i_hp_out(hpo),
    .i_hp_oe(hpoe), .i_ale(ale), .i_rd_n(rdn), .i_wr_n(wrn), .o_lp_level(lpi),
    .o_addr(maddr));

  // pin activity seen since the last move was launched
  always @(posedge i_clk) begin
    if (!rdn || !wrn) s_strb <= 1'b1;
    if (lpoe || hpoe) s_port <= 1'b1;
    if (hpoe) s_hp <= 1'b1;
  end

  task automatic cyc();
    @(posedge i_clk);
    #1;
  endtask

  task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string msg);
    comparisons++;
    if (got !== exp) begin
      err_total++;
      $display("[ERR] %0t %s: got %h expected %h", $time, msg, got, exp);
    end
  endtask

  task automatic reg_wr(input logic [7:0] a, input logic [7:0] d);
    sa = a;
    swd = d;
    sw = 1'b1;
    cyc();
    sw = 1'b0;
  endtask

  task automatic reg_chk(input logic [7:0] a, input logic [7:0] exp, input logic exp_hit);
    sa = a;
    cyc();
    chk({8'h00, srd}, {8'h00, exp}, "register read");
    chk({15'h0000, hit}, {15'h0000, exp_hit}, "register hit");
  endtask

  task automatic dat_chk(input logic [7:0] a, input logic i, input logic s,
                         input logic e_ram, input logic e_sfr);
    da = a;
    ind = i;
    stk = s;
    cyc();
    chk({14'h0000, iram, sfr}, {14'h0000, e_ram, e_sfr}, "data space select");
  endtask

  task automatic xmove(input logic ri, input logic wr, input logic [15:0] a,
                       input logic [7:0] d);
    int n;
    if (ri) xra = a[7:0];
    else begin
      dpd = a;
      dpw = 1'b1;
      cyc();
      dpw = 1'b0;
    end
    xri = ri;
    xw = wr;
    xwd = d;
    s_strb = 1'b0;
    s_port = 1'b0;
    s_hp = 1'b0;
    chk({15'h0000, busy}, 16'h0000, "busy before move");
    xq = 1'b1;
    cyc();
    xq = 1'b0;
    n = 0;
    while (done !== 1'b1 && n < 40) begin
      cyc();
      n++;
    end
    chk({15'h0000, done}, 16'h0001, "move done");
    // a request in the done cycle is refused
    cyc();
  endtask

  task automatic ale_cnt(output int k);
    k = 0;
    repeat (8) begin
      cyc();
      if (ale === 1'b1) k++;
    end
  endtask

  task automatic test_done(input string name);
    $display("test %s done, mismatches so far %0d", name, err_total);
  endtask

  task automatic end_sim();
    $display("comparisons %0d mismatches %0d", comparisons, err_total);
    if (err_total == 0 && comparisons > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask

  initial begin
    #(20 * 5000);
    err_total++;
    $display("[ERR] %0t watchdog expired", $time);
    end_sim();
  end

  initial begin
    repeat (16) @(posedge i_clk);
    #1;
    i_rst = 1'b0;
    cyc();
    reg_chk(AUX_MEM_ADDR, 8'h00, 1'b1);
    reg_chk(AUX_PSEL_ADDR, 8'h00, 1'b1);
    // reserved bits stay zero; the hard-wired bit 2 is still written high
    reg_wr(AUX_MEM_ADDR, 8'h03);
    reg_chk(AUX_MEM_ADDR, 8'h03, 1'b1);
    reg_wr(AUX_PSEL_ADDR, 8'h0D);
    reg_chk(AUX_PSEL_ADDR, 8'h09, 1'b1);
    reg_wr(8'h8F, 8'h55);
    reg_chk(8'h8F, 8'h00, 1'b0);
    reg_wr(AUX_PSEL_ADDR, 8'h08);
    reg_chk(AUX_PSEL_ADDR, 8'h08, 1'b1);
    test_done("registers");
    reg_wr(AUX_PSEL_ADDR, 8'h00);
    dpd = 16'h1234;
    dpw = 1'b1;
    cyc();
    dpw = 1'b0;
    reg_wr(AUX_PSEL_ADDR, 8'h01);
    dpd = 16'hABCD;
    dpw = 1'b1;
    cyc();
    dpw = 1'b0;
    chk(dpa, 16'hABCD, "second pointer");
    reg_wr(AUX_PSEL_ADDR, 8'h02);
    chk(dpa, 16'h1234, "select toggled by increment");
    dpi = 1'b1;
    cyc();
    dpi = 1'b0;
    chk(dpa, 16'h1235, "pointer increment");
    test_done("pointers");
    // overlay is only switched on while running above the low 8 kB
    ca = 16'h2000;
    cyc();
    bootn = 1'b0;
    cyc();
    chk({15'h0000, cboot}, 16'h0000, "overlay on, fetch above");
    ca = 16'h1FFF;
    cyc();
    chk({15'h0000, cboot}, 16'h0001, "boot overlay top");
    ca = 16'h2000;
    cyc();
    chk({15'h0000, cboot}, 16'h0000, "above overlay");
    bootn = 1'b1;
    ca = 16'h1234;
    cyc();
    chk({cboot, csec, coff[5:0]}, {1'b0, 9'h024, 6'h34}, "sector split");
    test_done("program space");
    dat_chk(8'h7F, 1'b0, 1'b0, 1'b1, 1'b0);
    dat_chk(8'h00, 1'b1, 1'b0, 1'b1, 1'b0);
    dat_chk(8'h80, 1'b0, 1'b0, 1'b0, 1'b1);
    dat_chk(8'hFF, 1'b1, 1'b0, 1'b1, 1'b0);
    dat_chk(8'hC0, 1'b0, 1'b1, 1'b1, 1'b0);
    test_done("data space");
    reg_wr(AUX_MEM_ADDR, 8'h00);
    ale_cnt(c);
    chk(16'(c), 16'h0004, "free latch strobe");
    reg_wr(AUX_MEM_ADDR, 8'h01);
    ale_cnt(c);
    chk(16'(c), 16'h0000, "quiet latch strobe");
    cmv = 1'b1;
    ale_cnt(c);
    cmv = 1'b0;
    chk(16'(c), 16'h0004, "latch strobe in code move");
    test_done("latch strobe");
    xmove(1'b0, 1'b1, 16'h02FF, 8'hA5);
    chk({14'h0000, s_strb, s_port}, 16'h0000, "local pins quiet");
    xmove(1'b1, 1'b1, 16'h0010, 8'h3C);
    chk({14'h0000, s_strb, onbus}, 16'h0000, "byte form local");
    xmove(1'b0, 1'b0, 16'h0010, 8'h00);
    chk({8'h00, xrd}, 16'h003C, "byte form index");
    xmove(1'b0, 1'b0, 16'h02FF, 8'h00);
    chk({7'h00, s_strb, xrd}, 16'h00A5, "expanded RAM top");
    for (int k = 0; k < 2; k++) begin
      xmove(1'b0, 1'b1, k ? 16'hFFFF : 16'h0300, 8'h96 ^ k[7:0]);
      chk({s_strb, s_hp, onbus}, 3'b111, "pointer bus write");
      chk(maddr, k ? 16'hFFFF : 16'h0300, "pointer bus address");
      xmove(1'b0, 1'b0, k ? 16'hFFFF : 16'h0300, 8'h00);
      chk({8'h00, xrd}, {8'h00, 8'h96 ^ k[7:0]}, "pointer bus read");
    end
    reg_wr(AUX_MEM_ADDR, 8'h02);
    xmove(1'b1, 1'b1, 16'h0077, 8'hC3);
    chk({s_strb, s_hp, onbus}, 3'b101, "byte form bus write");
    chk(maddr, 16'h0077, "byte form address");
    xmove(1'b1, 1'b0, 16'h0077, 8'h00);
    chk({8'h00, xrd}, 16'h00C3, "byte form bus read");
    xmove(1'b0, 1'b1, 16'h0010, 8'h81);
    xmove(1'b0, 1'b0, 16'h0010, 8'h00);
    chk({7'h00, onbus, xrd}, 16'h0181, "forced pointer move");
    test_done("external moves");
    end_sim();
  end
endmodule
